// *** src/cpie_pkg.sv ***
// Package: register map, field positions and carriers of the interrupt enable block
package cpie_pkg;
  // ==========================================================================
  // Register word indices (byte address is index times four)
  localparam logic [9:0] CoreCtlIdx0 = 10'h00b;
  localparam logic [9:0] CoreCtlIdx1 = 10'h08b;
  localparam logic [9:0] CoreCtlIdx2 = 10'h10b;
  localparam logic [9:0] CoreCtlIdx3 = 10'h18b;
  localparam logic [9:0] PerEnIdx    = 10'h08c;
  localparam logic [9:0] PerFlagIdx  = 10'h00c;
  localparam logic [9:0] WrapStatIdx = 10'h1f0;
  localparam logic [9:0] WrapMaskIdx = 10'h1f1;
  // ==========================================================================
  // Core control field positions
  localparam int GieBit  = 7;
  localparam int PeieBit = 6;
  localparam int T0ieBit = 5;
  localparam int EdgeEnBit = 4;
  localparam int PcieBit = 3;
  localparam int T0ifBit = 2;
  localparam int EdgeFlBit = 1;
  localparam int PcifBit = 0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CoreCtlRst = 8'h00;
  localparam logic [7:0] PerEnRst   = 8'h00;
  localparam logic [7:0] PerFlagRst = 8'h00;
  localparam logic [1:0] WrapRst    = 2'h0;
  // ==========================================================================
  // Wrapper status bit positions
  localparam int StatReqBit  = 0;
  localparam int StatPerBit  = 1;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } cpie_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cpie_wb_rsp_t;

  typedef struct packed {
    logic       timerZero;
    logic       edgePin;
    logic       portChange;
    logic [7:0] periph;
  } cpie_events_t;
endpackage

// *** src/cpie_irq_ctrl.sv ***
// Interrupt enable, flag and request logic with a classic Wishbone register slave
//
// Functional notes
// - Core control register holds timer-zero, port-change and edge pin enables and flags.
// - Core control register answers at four mirrored addresses, one physical register.
// - Flags set on every event regardless of own enable or global enable.
// - Bit 7 is global enable; clear means no request to the core.
// - Bit 6 gates every peripheral source onto the request.
// - Separate 8-bit peripheral enable register at its own address.
// - Enables for parallel slave, converter, serial, sync serial, capture, timers.
// - Peripheral flag register pairs each flag with the same enable bit position.
// - Peripheral flags stay set until software writes zero to them.
//
// The implementer's own choice: the Wishbone interface to the registers.
`default_nettype none
module cpie_irq_ctrl (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Wishbone slave
  input  wire cpie_pkg::cpie_wb_req_t wbReq,
  output var  cpie_pkg::cpie_wb_rsp_t wbRsp,
  // Event pulses, one clk each, same clock domain
  input  wire cpie_pkg::cpie_events_t events,
  // Request toward the core and wrapper interrupt
  output var  logic                  coreIrq,
  output var  logic                  irq
);
  // ==========================================================================
  // Register state
  logic [7:0] coreCtl_q;
  logic [7:0] perEn_q;
  logic [7:0] perFlag_q;
  logic [1:0] wrapStat_q;
  logic [1:0] wrapMask_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic       coreIrq_q;
  logic       irq_q;

  function automatic logic hitWord(input logic [11:0] adr, input logic [9:0] idx);
    hitWord = (adr[11:2] == idx);
  endfunction

  // ==========================================================================
  // Bus decode
  logic access;
  logic wrLow;
  logic hitCore;
  logic hitPerEn;
  logic hitPerFl;
  logic hitStat;
  logic hitMask;

  assign access   = wbReq.cyc && wbReq.stb && !ack_q;
  assign wrLow    = access && wbReq.we && wbReq.sel[0];
  assign hitCore  = hitWord(wbReq.adr, cpie_pkg::CoreCtlIdx0) ||
                    hitWord(wbReq.adr, cpie_pkg::CoreCtlIdx1) ||
                    hitWord(wbReq.adr, cpie_pkg::CoreCtlIdx2) ||
                    hitWord(wbReq.adr, cpie_pkg::CoreCtlIdx3);
  assign hitPerEn = hitWord(wbReq.adr, cpie_pkg::PerEnIdx);
  assign hitPerFl = hitWord(wbReq.adr, cpie_pkg::PerFlagIdx);
  assign hitStat  = hitWord(wbReq.adr, cpie_pkg::WrapStatIdx);
  assign hitMask  = hitWord(wbReq.adr, cpie_pkg::WrapMaskIdx);

  // ==========================================================================
  // Core control register
  logic [7:0] coreEv;
  always_comb begin
    coreEv = 8'h00;
    coreEv[cpie_pkg::T0ifBit]   = events.timerZero;
    coreEv[cpie_pkg::EdgeFlBit] = events.edgePin;
    coreEv[cpie_pkg::PcifBit]   = events.portChange;
  end

  // Hardware set beats a same-cycle software clear of a flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreCtl_q <= cpie_pkg::CoreCtlRst;
    end else if (wrLow && hitCore) begin
      coreCtl_q <= wbReq.dat[7:0] | coreEv;
    end else begin
      coreCtl_q <= coreCtl_q | coreEv;
    end
  end

  // ==========================================================================
  // Peripheral enable and flag registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perEn_q <= cpie_pkg::PerEnRst;
    end else if (wrLow && hitPerEn) begin
      perEn_q <= wbReq.dat[7:0];
    end
  end

  // Writing one leaves a flag alone; only a written zero clears it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perFlag_q <= cpie_pkg::PerFlagRst;
    end else if (wrLow && hitPerFl) begin
      perFlag_q <= (perFlag_q & wbReq.dat[7:0]) | events.periph;
    end else begin
      perFlag_q <= perFlag_q | events.periph;
    end
  end

  // ==========================================================================
  // Request logic
  logic coreHit;
  logic perHit;
  logic reqD;
  assign coreHit = (coreCtl_q[cpie_pkg::T0ieBit]   && coreCtl_q[cpie_pkg::T0ifBit])   ||
                   (coreCtl_q[cpie_pkg::EdgeEnBit] && coreCtl_q[cpie_pkg::EdgeFlBit]) ||
                   (coreCtl_q[cpie_pkg::PcieBit]   && coreCtl_q[cpie_pkg::PcifBit]);
  assign perHit  = coreCtl_q[cpie_pkg::PeieBit] && |(perEn_q & perFlag_q);
  assign reqD    = coreCtl_q[cpie_pkg::GieBit] && (coreHit || perHit);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreIrq_q <= 1'b0;
    end else begin
      coreIrq_q <= reqD;
    end
  end

  // ==========================================================================
  // Wrapper status: rising request and peripheral hit, write one to clear
  logic [1:0] wrapEv;
  logic       perHitDly_q;
  assign wrapEv = {perHit && !perHitDly_q, reqD && !coreIrq_q};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perHitDly_q <= 1'b0;
    end else begin
      perHitDly_q <= perHit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrapStat_q <= cpie_pkg::WrapRst;
    end else if (wrLow && hitStat) begin
      wrapStat_q <= (wrapStat_q & ~wbReq.dat[1:0]) | wrapEv;
    end else begin
      wrapStat_q <= wrapStat_q | wrapEv;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrapMask_q <= cpie_pkg::WrapRst;
    end else if (wrLow && hitMask) begin
      wrapMask_q <= wbReq.dat[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(wrapStat_q & wrapMask_q);
    end
  end

  // ==========================================================================
  // Bus answer: ack one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= access;
      rdat_q <= 32'h0000_0000;
      if (access && !wbReq.we) begin
        if (hitCore) begin
          rdat_q <= {24'h00_0000, coreCtl_q};
        end else if (hitPerEn) begin
          rdat_q <= {24'h00_0000, perEn_q};
        end else if (hitPerFl) begin
          rdat_q <= {24'h00_0000, perFlag_q};
        end else if (hitStat) begin
          rdat_q <= {30'h0000_0000, wrapStat_q};
        end else if (hitMask) begin
          rdat_q <= {30'h0000_0000, wrapMask_q};
        end
      end
    end
  end

  assign wbRsp.ack = ack_q;
  assign wbRsp.dat = rdat_q;
  assign coreIrq   = coreIrq_q;
  assign irq       = irq_q;
endmodule // cpie_irq_ctrl
`default_nettype wire

// *** bench/cpie_core_model.sv ***
// Core side model: counts interrupt entries
`default_nettype none
module cpie_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request and entry count
  input  wire logic       coreIrq,
  output var  logic [7:0] entries
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irqQ;
  always_ff @(posedge clk) begin
    irqQ <= rst_n && coreIrq;
    if (!rst_n) entries <= 8'h0;
    else if (coreIrq && !irqQ) entries <= entries + 8'h1;
  end
endmodule  // cpie_core_model
`default_nettype wire

// *** bench/cpie_irq_chk.sv ***
// Checker: bus timing, readback and request gating
`default_nettype none
module cpie_irq_chk (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Watched ports
  input wire cpie_pkg::cpie_wb_req_t wbReq,
  input wire cpie_pkg::cpie_wb_rsp_t wbRsp,
  input wire cpie_pkg::cpie_events_t events,
  input wire logic                   coreIrq,
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] enQ;
  logic [7:0] perEnQ;
  logic       wr;
  logic       rdA;
  logic       isCtl;
  logic       isEn;
  assign wr = wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack && wbReq.sel[0];
  assign rdA = wbRsp.ack && !wbReq.we;
  // All four mirrors share these index bits
  assign isCtl = !wbReq.adr[11] && wbReq.adr[8:2] == 7'h0b;
  assign isEn = wbReq.adr[11:2] == cpie_pkg::PerEnIdx;
  // Enables only change by software, so a shadow is exact
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enQ <= 5'h0;
      perEnQ <= 8'h0;
    end else if (wr && isCtl) enQ <= wbReq.dat[7:3];
    else if (wr && isEn) perEnQ <= wbReq.dat[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("ack late");
  a_ack_pulse: assert property (wbRsp.ack |=> !wbRsp.ack) else $error("ack too long");
  a_upper_zero: assert property (wbRsp.ack |-> wbRsp.dat[31:8] == 24'h0)
    else $error("upper bits set");
  a_ctl_read: assert property (rdA && isCtl |-> wbRsp.dat[7:3] == enQ)
    else $error("control readback");
  a_en_read: assert property (rdA && isEn |-> wbRsp.dat[7:0] == perEnQ)
    else $error("enable readback");
  a_gie_off: assert property (!enQ[4] |=> !coreIrq) else $error("request without global");
  a_peripheral_group_enable_off: assert property (!enQ[3] && enQ[2:0] == 3'h0 |=> !coreIrq)
    else $error("peripheral not gated");
  a_t0_req: assert property (enQ[4] && enQ[2] && events.timerZero |-> ##[1:2] coreIrq)
    else $error("timer request missing");
  c_core: cover property ($rose(coreIrq));
  c_wrap: cover property ($rose(irq));
  c_ctl: cover property (wr && isCtl);
endmodule  // cpie_irq_chk
bind cpie_irq_ctrl cpie_irq_chk u_chk (.clk(clk), .rst_n(rst_n), .wbReq(wbReq),
  .wbRsp(wbRsp), .events(events), .coreIrq(coreIrq), .irq(irq));
`default_nettype wire

// *** bench/cpie_irq_ctrl_tb_top.sv ***
// Testbench: register access, event flags, request gating
`default_nettype none
module cpie_irq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   coreIrq;
  logic                   irq;
  logic [7:0]             entries;
  int                     n_fail = 0;
  int                     checked = 0;
  cpie_pkg::cpie_wb_req_t wbReq = '0;
  cpie_pkg::cpie_wb_rsp_t wbRsp;
  cpie_pkg::cpie_events_t events = '0;
  always #5 clk = ~clk;
  cpie_irq_ctrl u_dut (.clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .events(events), .coreIrq(coreIrq), .irq(irq));
  cpie_core_model u_core (.clk(clk), .rst_n(rst_n), .coreIrq(coreIrq), .entries(entries));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(logic w, logic [9:0] ix, logic [7:0] d, output logic [31:0] q);
    int k;
    wbReq <= '{1'b1, 1'b1, w, 4'hf, {ix, 2'h0}, {24'h0, d}};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wbRsp.ack !== 1'b1 && k < 20);
    if (wbRsp.ack !== 1'b1) begin
      n_fail++;
      conclude();
    end
    q = wbRsp.dat;
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic rd(string nm, logic [9:0] ix, logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, ix, 8'h0, q);
    chk(nm, e, q);
  endtask
  task automatic wr(logic [9:0] ix, logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, ix, d, q);
  endtask
  task automatic ev(cpie_pkg::cpie_events_t e);
    events <= e;
    @(posedge clk);
    events <= '0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd("reset", {1'b0, 2'(i), 7'h0c}, 32'h0);
    wr(cpie_pkg::CoreCtlIdx1, 8'h38);
    for (int i = 0; i < 4; i++) rd("mirror", {1'b0, 2'(i), 7'h0b}, 32'h38);
    ev('{1'b1, 1'b1, 1'b1, 8'h0});
    rd("flags", cpie_pkg::CoreCtlIdx3, 32'h3f);
    chk("coreIrq", 32'h0, {31'h0, coreIrq});
    wr(cpie_pkg::CoreCtlIdx0, 8'hb8);
    ev('{1'b0, 1'b1, 1'b0, 8'h0});
    chk("coreIrq", 32'h1, {31'h0, coreIrq});
    chk("entries", 32'h1, {24'h0, entries});
    ev('{1'b1, 1'b0, 1'b0, 8'h0});
    rd("t0flag", cpie_pkg::CoreCtlIdx2, 32'hbe);
    wr(cpie_pkg::CoreCtlIdx0, 8'h80);
    wr(cpie_pkg::PerEnIdx, 8'hff);
    ev('{1'b0, 1'b0, 1'b0, 8'h81});
    rd("perFlag", cpie_pkg::PerFlagIdx, 32'h81);
    chk("coreIrq", 32'h0, {31'h0, coreIrq});
    wr(cpie_pkg::CoreCtlIdx0, 8'hc0);
    chk("coreIrq", 32'h1, {31'h0, coreIrq});
    wr(cpie_pkg::PerFlagIdx, 8'h01);
    rd("perFlag", cpie_pkg::PerFlagIdx, 32'h01);
    wr(cpie_pkg::PerFlagIdx, 8'h00);
    chk("coreIrq", 32'h0, {31'h0, coreIrq});
    rd("status", cpie_pkg::WrapStatIdx, 32'h3);
    wr(cpie_pkg::WrapMaskIdx, 8'h01);
    chk("irq", 32'h1, {31'h0, irq});
    wr(cpie_pkg::WrapStatIdx, 8'h01);
    chk("irq", 32'h0, {31'h0, irq});
    rd("status", cpie_pkg::WrapStatIdx, 32'h2);
    wr(10'h3ff, 8'hff);
    rd("unmapped", 10'h3ff, 32'h0);
    rd("perEn", cpie_pkg::PerEnIdx, 32'hff);
    conclude();
  end
endmodule  // cpie_irq_ctrl_tb_top
`default_nettype wire
